// >>> hw/cqp_pkg.sv
// Purpose: Shared types and constants for the charge quota policy control
// Assumes: One 25 MHz clock, synchronous active-low reset
// Notes:   Behaviour codes and power state codes live here only
package cqp_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 40;

    // Auto-recovery wait between fault checks
    localparam int T_CYCLE_US    = 20;
    localparam int CYCLE_CNT     = (T_CYCLE_US * 1000) / CLK_PERIOD_NS;

    // Quota behaviour codes
    typedef enum logic [1:0] {
        BEH_REPORT = 2'h0,
        BEH_REP_DISC = 2'h1,
        BEH_DISC_SLEEP = 2'h2,
        BEH_IGNORE = 2'h3
    } cqp_beh_t;

    // Power states, Gray along detect, active, error, sleep
    typedef enum logic [1:0] {
        PS_DETECT = 2'h0,
        PS_ACTIVE = 2'h1,
        PS_ERROR  = 2'h3,
        PS_SLEEP  = 2'h2
    } cqp_pstate_t;

    // Control pins that decide the power state
    typedef struct packed {
        logic mode_sel_a;
        logic mode_sel_b;
        logic emulation_enable;
        logic detect_policy;
        logic port_power_enable;
    } cqp_ctl_t;

    // Fault sources
    typedef struct packed {
        logic overcurrent;
        logic supply_ov;
        logic bus_uv;
        logic back_voltage;
        logic discharge_err;
        logic over_temp;
    } cqp_fault_t;

    // Ordered action steps, lowest index runs first
    localparam int STEPS      = 6;
    localparam int STEP_FLAG  = 0;
    localparam int STEP_ALERT = 1;
    localparam int STEP_EMU   = 2;
    localparam int STEP_SW    = 3;
    localparam int STEP_SLEEP = 4;
    localparam int STEP_CHECK = 5;

    // Reset values
    localparam logic [1:0] BEH_RST = 2'h1;

endpackage : cqp_pkg

// >>> hw/cqp_policy_ctrl.sv
// Purpose: Quota policy, quota enable/clear and fault handling control
// Assumes: Accumulator and detection logic live outside on the same clock
// Notes:   Actions run one step per clock in a fixed order
//
// Operation
// - Report to report-and-disconnect after hit: open switch, keep alert
// - Report to disconnect-and-sleep: release alert, drop profile, open, sleep
// - Report-and-disconnect to disconnect-and-sleep: release alert, then sleep
// - Disconnect-and-sleep to report: assert alert, then re-check controls
// - Disconnect-and-sleep to report-and-disconnect: alert, re-check, switches open
// - Re-check restarts emulation if controls changed, else prior state
// - Quota disable before hit disables quota and clears count
// - Quota disable after hit clears flag, releases alert, re-checks
// - Quota clear zeroes accumulated count
// - Clear before hit keeps counting; after hit runs behaviour reset steps
// - Latched and auto-recovering fault handling both supported
// - Hold mode from config bit on SMBus, else from hold pin
// - Faults: overcurrent, overvoltage, undervoltage, back-voltage, discharge, heat
// - Report reset: clear count, clear flag, release alert, in order
// - Auto mode: error, alert, wait, re-check, restore active
// - Latched mode: stay in error until power toggle or flag clear
`timescale 1ns/100ps
`default_nettype none
module cqp_policy_ctrl #(
    parameter int CYCLE_CNT = cqp_pkg::CYCLE_CNT
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Control pins
    input  wire cqp_pkg::cqp_ctl_t    ctl_pins,
    input  wire logic                 quota_enable,
    input  wire logic                 fault_hold_pin,
    input  wire cqp_pkg::cqp_fault_t  fault_pins,
    input  wire logic                 detect_alert,
    // Host configuration logic
    input  wire logic                 smbus_active,
    input  wire logic                 fault_hold_select_bit,
    input  wire logic                 behavior_wr,
    input  wire cqp_pkg::cqp_beh_t    behavior_in,
    input  wire logic                 quota_clear,
    input  wire logic                 fault_flag_clear,
    // Accumulator
    input  wire logic                 threshold_hit,
    output logic                      accum_clear,
    // Port control
    output logic                      alert_n,
    output logic                      port_switch_on,
    output logic                      bypass_switch_on,
    output logic                      emulation_on,
    output logic                      emulation_restart,
    // Status
    output cqp_pkg::cqp_pstate_t      power_state,
    output logic                      quota_hit_flag,
    output logic                      fault_flag,
    output cqp_pkg::cqp_beh_t         prev_behavior,
    output cqp_pkg::cqp_beh_t         cur_behavior
);
    localparam int CW = $clog2(CYCLE_CNT + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYCLE_CNT - 1);

    typedef struct packed {
        cqp_pkg::cqp_pstate_t ps;
        cqp_pkg::cqp_pstate_t ps_prior;
        cqp_pkg::cqp_beh_t    beh;
        cqp_pkg::cqp_beh_t    beh_prev;
        logic                 hit;
        logic                 alert_quota;
        logic                 alert_target;
        logic                 sw_block;
        logic                 emu_removed;
        logic [cqp_pkg::STEPS-1:0] pending;
        cqp_pkg::cqp_ctl_t    ctl_snap;
        logic                 thr_d;
        logic                 en_d;
        logic                 pwr_d;
        logic                 fflag;
        logic [CW-1:0]        cyc;
        logic                 alert_n;
        logic                 sw_on;
        logic                 byp_on;
        logic                 emu_on;
        logic                 emu_restart;
        logic                 acc_clr;
    } cqp_st_t;

    cqp_st_t s;
    cqp_st_t next_s;

    cqp_pkg::cqp_ctl_t   ctl;
    cqp_pkg::cqp_fault_t flt;
    logic                q_en;
    logic                hold_pin;
    logic                det_alert;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    cqp_sync #(
        .W ($bits(cqp_pkg::cqp_ctl_t) + $bits(cqp_pkg::cqp_fault_t) + 3)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({ctl_pins, fault_pins, quota_enable, fault_hold_pin, detect_alert}),
        .dout  ({ctl, flt, q_en, hold_pin, det_alert})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    logic                       fault_any;
    logic                       latch_mode;
    logic                       en_fall;
    logic                       pwr_fall;
    logic [cqp_pkg::STEPS-1:0]  step;

    // Action mask for a behaviour change after the hit
    function automatic logic [cqp_pkg::STEPS-1:0] beh_mask(
        input cqp_pkg::cqp_beh_t o,
        input cqp_pkg::cqp_beh_t n
    );
        logic [cqp_pkg::STEPS-1:0] m;
        m = '0;
        case ({o, n})
            {cqp_pkg::BEH_REPORT, cqp_pkg::BEH_REP_DISC}: m[cqp_pkg::STEP_SW] = 1'b1;
            {cqp_pkg::BEH_REPORT, cqp_pkg::BEH_DISC_SLEEP}: m = 6'b01_1110;
            {cqp_pkg::BEH_REPORT, cqp_pkg::BEH_IGNORE}: m[cqp_pkg::STEP_ALERT] = 1'b1;
            {cqp_pkg::BEH_REP_DISC, cqp_pkg::BEH_IGNORE}: m = 6'b10_0010;
            {cqp_pkg::BEH_REP_DISC, cqp_pkg::BEH_REPORT}: m[cqp_pkg::STEP_CHECK] = 1'b1;
            {cqp_pkg::BEH_REP_DISC, cqp_pkg::BEH_DISC_SLEEP}: m = 6'b01_0010;
            {cqp_pkg::BEH_DISC_SLEEP, cqp_pkg::BEH_IGNORE}: m[cqp_pkg::STEP_CHECK] = 1'b1;
            {cqp_pkg::BEH_DISC_SLEEP, cqp_pkg::BEH_REPORT}: m = 6'b10_0010;
            {cqp_pkg::BEH_DISC_SLEEP, cqp_pkg::BEH_REP_DISC}: m = 6'b10_0010;
            {cqp_pkg::BEH_IGNORE, cqp_pkg::BEH_REPORT}: m[cqp_pkg::STEP_ALERT] = 1'b1;
            {cqp_pkg::BEH_IGNORE, cqp_pkg::BEH_REP_DISC}: m = 6'b00_1110;
            {cqp_pkg::BEH_IGNORE, cqp_pkg::BEH_DISC_SLEEP}: m = 6'b01_1100;
            default: m = '0;
        endcase
        return m;
    endfunction

    always_comb begin
        next_s             = s;
        next_s.emu_restart = 1'b0;
        next_s.acc_clr     = 1'b0;
        next_s.thr_d       = threshold_hit;
        next_s.en_d        = q_en;
        next_s.pwr_d       = ctl.port_power_enable;
        fault_any  = |flt;
        latch_mode = smbus_active ? fault_hold_select_bit : hold_pin;
        en_fall    = s.en_d & ~q_en;
        pwr_fall   = s.pwr_d & ~ctl.port_power_enable;
        step       = '0;
        for (int i = cqp_pkg::STEPS - 1; i >= 0; i--) begin
            if (s.pending[i]) begin
                step = '0;
                step[i] = 1'b1;
            end
        end

        // One ordered step per clock
        next_s.pending = s.pending & ~step;
        if (step[cqp_pkg::STEP_FLAG]) begin
            next_s.hit = 1'b0;
        end
        if (step[cqp_pkg::STEP_ALERT]) begin
            next_s.alert_quota = s.alert_target;
        end
        if (step[cqp_pkg::STEP_EMU]) begin
            next_s.emu_removed = 1'b1;
        end
        if (step[cqp_pkg::STEP_SW]) begin
            next_s.sw_block = 1'b1;
        end
        if (step[cqp_pkg::STEP_SLEEP] && s.ps != cqp_pkg::PS_ERROR) begin
            next_s.ps = cqp_pkg::PS_SLEEP;
        end
        if (step[cqp_pkg::STEP_CHECK]) begin
            next_s.sw_block = s.hit && s.beh == cqp_pkg::BEH_REP_DISC;
            if (ctl != s.ctl_snap) begin
                next_s.ctl_snap    = ctl;
                next_s.emu_removed = 1'b0;
                next_s.emu_restart = ctl.emulation_enable;
                if (s.ps != cqp_pkg::PS_ERROR) begin
                    next_s.ps = ctl.port_power_enable ? cqp_pkg::PS_ACTIVE
                                                      : cqp_pkg::PS_DETECT;
                end
            end else if (s.ps != cqp_pkg::PS_ERROR) begin
                next_s.ps = s.ps_prior;
            end
        end

        // Threshold reached
        if (threshold_hit && !s.thr_d && q_en && !s.hit) begin
            next_s.hit      = 1'b1;
            next_s.ctl_snap = ctl;
            next_s.ps_prior = s.ps;
            case (s.beh)
                cqp_pkg::BEH_REPORT: next_s.alert_quota = 1'b1;
                cqp_pkg::BEH_REP_DISC: begin
                    next_s.alert_quota = 1'b1;
                    next_s.emu_removed = 1'b1;
                    next_s.sw_block    = 1'b1;
                end
                cqp_pkg::BEH_DISC_SLEEP: next_s.pending[4:2] = 3'h7;
                default: next_s.pending = next_s.pending;
            endcase
        end

        if (behavior_wr) begin
            next_s.beh_prev = s.beh;
            next_s.beh      = behavior_in;
            if (s.hit) begin
                next_s.pending      = next_s.pending | beh_mask(s.beh, behavior_in);
                next_s.alert_target = behavior_in == cqp_pkg::BEH_REPORT ||
                                      behavior_in == cqp_pkg::BEH_REP_DISC;
            end
        end

        if (quota_clear) begin
            next_s.acc_clr = 1'b1;
            if (s.hit) begin
                next_s.alert_target = 1'b0;
                case (s.beh)
                    cqp_pkg::BEH_REPORT: next_s.pending = next_s.pending | 6'b00_0011;
                    cqp_pkg::BEH_REP_DISC: next_s.pending = next_s.pending | 6'b10_0011;
                    cqp_pkg::BEH_DISC_SLEEP: next_s.pending = next_s.pending | 6'b10_0001;
                    default: next_s.pending = next_s.pending | 6'b00_0001;
                endcase
            end
        end

        if (en_fall && !s.hit) begin
            next_s.acc_clr = 1'b1;
        end
        if (en_fall && s.hit) begin
            next_s.hit          = 1'b0;
            next_s.alert_target = 1'b0;
            next_s.pending      = next_s.pending | 6'b10_0010;
        end

        if (fault_any) begin
            next_s.fflag = 1'b1;
        end else if (fault_flag_clear) begin
            next_s.fflag = 1'b0;
        end
        if (fault_any && s.ps != cqp_pkg::PS_ERROR) begin
            next_s.ps  = cqp_pkg::PS_ERROR;
            next_s.cyc = '0;
        end else if (s.ps == cqp_pkg::PS_ERROR) begin
            if (latch_mode) begin
                if ((pwr_fall || fault_flag_clear) && !fault_any) begin
                    next_s.ps = cqp_pkg::PS_ACTIVE;
                end
            end else begin
                next_s.cyc = s.cyc + CW'(1);
                if (s.cyc == CYC_LAST) begin
                    next_s.cyc = '0;
                    if (!fault_any) begin
                        next_s.ps = cqp_pkg::PS_ACTIVE;
                    end
                end
            end
        end

        next_s.alert_n = ~(next_s.alert_quota || next_s.ps == cqp_pkg::PS_ERROR || det_alert);
        next_s.sw_on   = next_s.ps == cqp_pkg::PS_ACTIVE && !next_s.sw_block;
        next_s.byp_on  = next_s.ps == cqp_pkg::PS_DETECT && !next_s.sw_block;
        next_s.emu_on  = next_s.ps == cqp_pkg::PS_ACTIVE && ctl.emulation_enable &&
                         !next_s.emu_removed;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s         <= '0;
            s.alert_n <= 1'b1;
            s.beh     <= cqp_pkg::cqp_beh_t'(cqp_pkg::BEH_RST);
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign accum_clear       = s.acc_clr;
    assign alert_n           = s.alert_n;
    assign port_switch_on    = s.sw_on;
    assign bypass_switch_on  = s.byp_on;
    assign emulation_on      = s.emu_on;
    assign emulation_restart = s.emu_restart;
    assign power_state       = s.ps;
    assign quota_hit_flag    = s.hit;
    assign fault_flag        = s.fflag;
    assign prev_behavior     = s.beh_prev;
    assign cur_behavior      = s.beh;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rd_switch_open_a: assert property (
        behavior_wr && s.hit && s.beh == cqp_pkg::BEH_REPORT && !en_fall && !quota_clear
        && behavior_in == cqp_pkg::BEH_REP_DISC |-> ##[1:4] (!port_switch_on && !alert_n))
        else $error("switch not opened with alert kept");
    sleep_state_a: assert property (
        step[cqp_pkg::STEP_SLEEP] && s.beh_prev == cqp_pkg::BEH_REPORT
        && s.beh == cqp_pkg::BEH_DISC_SLEEP |-> !s.alert_quota && s.emu_removed && s.sw_block)
        else $error("sleep entered before release steps");
    rd_to_sleep_a: assert property (
        behavior_wr && s.hit && s.beh == cqp_pkg::BEH_REP_DISC && s.pending == '0
        && behavior_in == cqp_pkg::BEH_DISC_SLEEP && !fault_any && !quota_clear && !en_fall
        |-> ##3 s.ps == cqp_pkg::PS_SLEEP)
        else $error("sleep not entered after release");
    check_prior_a: assert property (
        step[cqp_pkg::STEP_CHECK] && ctl == s.ctl_snap && s.ps != cqp_pkg::PS_ERROR
        && !fault_any |=> !emulation_restart && s.ps == $past(s.ps_prior))
        else $error("unchanged controls left prior state");
    disable_clear_a: assert property (
        en_fall && !s.hit |=> accum_clear)
        else $error("count not cleared on disable");
    disable_hit_a: assert property (
        en_fall && s.hit |=> !quota_hit_flag ##[0:3] s.pending == '0)
        else $error("flag kept after disable");
    clear_count_a: assert property (
        quota_clear |=> accum_clear)
        else $error("clear did not zero count");
    fault_enter_a: assert property (
        fault_any |=> power_state == cqp_pkg::PS_ERROR)
        else $error("fault did not enter error");
    auto_restore_a: assert property (
        s.ps == cqp_pkg::PS_ERROR && !latch_mode && s.cyc == CYC_LAST && !fault_any
        |=> power_state == cqp_pkg::PS_ACTIVE)
        else $error("auto recovery did not restore");
    latch_hold_a: assert property (
        s.ps == cqp_pkg::PS_ERROR && latch_mode && !pwr_fall && !fault_flag_clear
        |=> power_state == cqp_pkg::PS_ERROR)
        else $error("latched error left without command");
    beh_pair_a: assert property (
        behavior_wr |=> prev_behavior == $past(s.beh) && cur_behavior == $past(behavior_in))
        else $error("behaviour pair not registered");
    alert_any_a: assert property (
        s.ps == cqp_pkg::PS_ERROR || s.alert_quota |-> !alert_n)
        else $error("alert released with source active");

    cov_hit_c: cover property (threshold_hit && !s.thr_d && q_en && !s.hit);
    cov_sleep_c: cover property (step[cqp_pkg::STEP_SLEEP]);
    cov_restart_c: cover property (emulation_restart);
    cov_recover_c: cover property (s.ps == cqp_pkg::PS_ERROR ##1 s.ps == cqp_pkg::PS_ACTIVE);
endmodule // cqp_policy_ctrl
`default_nettype wire

// >>> hw/cqp_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module cqp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } cqp_sync_st_t;

    cqp_sync_st_t s;
    cqp_sync_st_t next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = din;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.stable;
endmodule // cqp_sync
`default_nettype wire

// >>> tb/cqp_host_model.sv
// Purpose: Host controller model for the quota policy block
// Assumes: Driven from the bench, changes just after rising edges
// Notes:   Strobes are one cycle wide, pins are plain levels
`timescale 1ns/100ps
`default_nettype none
module cqp_host_model (
    // Clock
    input  wire logic         clk,
    // Pins and configuration, mode is {smbus, select bit, hold pin}
    output cqp_pkg::cqp_ctl_t ctl_pins,
    output logic              quota_enable,
    output logic [2:0]        mode,
    // Strobes {behaviour write, quota clear, fault flag clear}
    output logic [2:0]        strb,
    output cqp_pkg::cqp_beh_t behavior_in
);
    initial begin
        ctl_pins     = 5'h0d;
        quota_enable = 1'b1;
        mode         = 3'h0;
        strb         = 3'h0;
        behavior_in  = cqp_pkg::BEH_REPORT;
    end
    task automatic pins(input cqp_pkg::cqp_ctl_t c, input logic q, input logic [2:0] m);
        @(posedge clk);
        ctl_pins     <= c;
        quota_enable <= q;
        mode         <= m;
    endtask
    task automatic strobe(input logic [2:0] s, input cqp_pkg::cqp_beh_t b);
        @(posedge clk);
        strb        <= s;
        behavior_in <= b;
        @(posedge clk);
        strb        <= 3'h0;
        #1;
    endtask
endmodule // cqp_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the quota policy control
// Assumes: Recovery wait shortened to 8 clocks
// Notes:   Pin changes land 3 edges late, strobes answer from the next edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                 clk           = 1'b0;
    logic                 rst_n         = 1'b0;
    logic                 threshold_hit = 1'b0;
    logic                 detect_alert  = 1'b0;
    cqp_pkg::cqp_fault_t  fault_pins    = '0;
    cqp_pkg::cqp_ctl_t    ctl_pins;
    cqp_pkg::cqp_beh_t    behavior_in, prev_behavior, cur_behavior;
    cqp_pkg::cqp_pstate_t power_state;
    logic                 quota_enable, latched;
    logic [2:0]           mode, strb;
    logic                 accum_clear, alert_n, port_switch_on, bypass_switch_on;
    logic                 emulation_on, emulation_restart, quota_hit_flag, fault_flag;
    int                   num_errors = 0;
    int                   n_compared = 0;
    int                   n_clear    = 0;
    int                   n_restart  = 0;
    int                   base;
`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

    always #20 clk = ~clk;
    // Pulses are counted, since one-cycle outputs are easy to miss by sampling
    always @(posedge clk) begin
        n_clear   <= n_clear + int'(accum_clear === 1'b1);
        n_restart <= n_restart + int'(emulation_restart === 1'b1);
    end

    cqp_host_model i_host (.clk, .ctl_pins, .quota_enable, .mode, .strb, .behavior_in);
    cqp_policy_ctrl #(.CYCLE_CNT(8)) i_dut (
        .clk, .rst_n, .ctl_pins, .quota_enable, .fault_hold_pin(mode[0]),
        .fault_pins, .detect_alert, .smbus_active(mode[2]),
        .fault_hold_select_bit(mode[1]), .behavior_wr(strb[2]), .behavior_in,
        .quota_clear(strb[1]), .fault_flag_clear(strb[0]), .threshold_hit,
        .accum_clear, .alert_n, .port_switch_on, .bypass_switch_on, .emulation_on,
        .emulation_restart, .power_state, .quota_hit_flag, .fault_flag,
        .prev_behavior, .cur_behavior
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (num_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic [2:0] m);
        @(posedge clk);
        rst_n         <= 1'b0;
        threshold_hit <= 1'b0;
        fault_pins    <= '0;
        detect_alert  <= 1'b0;
        i_host.pins(5'h0d, 1'b1, m);
        @(posedge clk);
        rst_n <= 1'b1;
        at(4);
    endtask
    task automatic arm(input cqp_pkg::cqp_beh_t b);
        do_reset(3'h0);
        i_host.strobe(3'h4, b);
        @(posedge clk);
        threshold_hit <= 1'b1;
        at(3);
        `CMP(quota_hit_flag, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(3'h0);
        `CMP(cur_behavior, cqp_pkg::BEH_REP_DISC)
        `CMP(alert_n, 1'b1)
        arm(cqp_pkg::BEH_REPORT);
        `CMP(alert_n, 1'b0)
        i_host.strobe(3'h4, cqp_pkg::BEH_DISC_SLEEP);
        `CMP({prev_behavior, cur_behavior}, 4'h2)
        at(1);
        `CMP({alert_n, power_state == cqp_pkg::PS_SLEEP}, 2'h2)
        at(1);
        `CMP(emulation_on, 1'b0)
        at(1);
        `CMP(port_switch_on, 1'b0)
        at(1);
        `CMP(power_state, cqp_pkg::PS_SLEEP)
        i_host.strobe(3'h4, cqp_pkg::BEH_REPORT);
        at(1);
        `CMP(alert_n, 1'b0)
        i_host.strobe(3'h4, cqp_pkg::BEH_REP_DISC);
        at(6);
        `CMP({alert_n, port_switch_on}, 2'h0)
        // Controls differ from the snapshot, so the re-check must restart
        i_host.pins(5'h1d, 1'b1, 3'h0);
        at(4);
        base = n_restart;
        i_host.strobe(3'h4, cqp_pkg::BEH_IGNORE);
        at(1);
        `CMP(alert_n, 1'b1)
        at(6);
        `CMP(n_restart - base, 1)
        `CMP({port_switch_on, emulation_on}, 2'h3)
        // Switch is closed now, so opening it is visible
        i_host.strobe(3'h4, cqp_pkg::BEH_REPORT);
        i_host.strobe(3'h4, cqp_pkg::BEH_REP_DISC);
        at(2);
        `CMP({alert_n, port_switch_on}, 2'h0)
        arm(cqp_pkg::BEH_REPORT);
        i_host.strobe(3'h2, cqp_pkg::BEH_REPORT);
        `CMP(accum_clear, 1'b1)
        at(1);
        `CMP({quota_hit_flag, alert_n}, 2'h0)
        at(1);
        `CMP(alert_n, 1'b1)
        arm(cqp_pkg::BEH_REP_DISC);
        `CMP({alert_n, port_switch_on, bypass_switch_on, emulation_on}, 4'h0)
        i_host.strobe(3'h4, cqp_pkg::BEH_DISC_SLEEP);
        at(1);
        `CMP(alert_n, 1'b1)
        at(3);
        `CMP(power_state, cqp_pkg::PS_SLEEP)
        i_host.strobe(3'h4, cqp_pkg::BEH_REP_DISC);
        at(6);
        `CMP({alert_n, port_switch_on, bypass_switch_on}, 3'h0)
        arm(cqp_pkg::BEH_REPORT);
        @(posedge clk);
        detect_alert <= 1'b1;
        i_host.pins(5'h0d, 1'b0, 3'h0);
        at(5);
        `CMP({quota_hit_flag, alert_n}, 2'h0)
        @(posedge clk);
        detect_alert <= 1'b0;
        at(5);
        `CMP(alert_n, 1'b1)
        do_reset(3'h0);
        base = n_clear;
        i_host.pins(5'h0d, 1'b0, 3'h0);
        at(5);
        `CMP(n_clear - base, 1)
        @(posedge clk);
        threshold_hit <= 1'b1;
        at(3);
        `CMP(quota_hit_flag, 1'b0)
        do_reset(3'h0);
        base = n_clear;
        i_host.strobe(3'h2, cqp_pkg::BEH_REPORT);
        at(2);
        `CMP(n_clear - base, 1)
        @(posedge clk);
        threshold_hit <= 1'b1;
        at(3);
        `CMP(quota_hit_flag, 1'b1)
        // Each fault source once; the unused hold source is set opposite
        for (int i = 0; i < 6; i++) begin
            latched = i[1];
            do_reset({i[0], ~(latched ^ i[0]), latched ^ i[0]});
            @(posedge clk);
            fault_pins <= cqp_pkg::cqp_fault_t'(6'h01 << i);
            at(3);
            `CMP({power_state, alert_n, fault_flag}, 4'hd)
            @(posedge clk);
            fault_pins <= '0;
            at(24);
            `CMP(power_state, latched ? cqp_pkg::PS_ERROR : cqp_pkg::PS_ACTIVE)
            if (latched) begin
                if (i[0]) i_host.strobe(3'h1, cqp_pkg::BEH_REPORT);
                else i_host.pins(5'h0c, 1'b1, 3'h1);
                at(6);
                `CMP(power_state == cqp_pkg::PS_ERROR, 1'b0)
            end
        end
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
